// ### hw/bam_pkg.sv
`default_nettype none
package bam_pkg;

  // bus geometry
  localparam int AXI_AW = 18;
  localparam int IDX_W  = 16;

  // register indexes, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_BREAK_STAT_CTRL = 16'hFE0B;
  localparam logic [IDX_W-1:0] IDX_BP_ADDR_HIGH    = 16'hFE0C;
  localparam logic [IDX_W-1:0] IDX_BP_ADDR_LOW     = 16'hFE0D;
  localparam logic [IDX_W-1:0] IDX_BREAK_FLAG_CTRL = 16'hFE0E;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS      = 16'hFE0F;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK        = 16'hFE10;
  localparam logic [IDX_W-1:0] IDX_SYS_STATUS      = 16'hFE11;

  // field positions
  localparam int BSC_ENABLE_BIT = 7;
  localparam int BSC_ACTIVE_BIT = 6;
  localparam int BFC_FCBE_BIT   = 7;
  localparam int SST_WAIT_BIT   = 0;
  localparam int SST_BREAK_BIT  = 1;
  localparam int SST_HV_BIT     = 2;
  localparam int IRQ_START_BIT  = 0;
  localparam int IRQ_END_BIT    = 1;
  localparam int IRQ_WAIT_BIT   = 2;
  localparam int IRQ_W          = 3;

  // reset values
  localparam logic [7:0]       BYTE_RST = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_RST  = 3'h0;

  // vector addresses
  localparam logic [15:0] VEC_USER_HIGH = 16'hFFFC;
  localparam logic [15:0] VEC_USER_LOW  = 16'hFFFD;
  localparam logic [15:0] VEC_MON_HIGH  = 16'hFEFC;
  localparam logic [15:0] VEC_MON_LOW   = 16'hFEFD;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    BRK_IDLE   = 2'b00,
    BRK_PEND   = 2'b01,
    BRK_ACTIVE = 2'b10
  } bam_brk_e;

  typedef struct packed {
    bam_brk_e         brk_st;
    logic             bsc_en;
    logic             act;
    logic [7:0]       bp_hi;
    logic [7:0]       bp_lo;
    logic             fcbe;
    logic             wait_brk;
    logic [IRQ_W-1:0] ist;
    logic [IRQ_W-1:0] imk;
    logic             hv_s1;
    logic             hv_s2;
    logic [15:0]      vec_hi;
    logic [15:0]      vec_lo;
    logic             aw_held;
    logic [IDX_W-1:0] aw_idx;
    logic             w_held;
    logic [7:0]       w_byte;
    logic             w_lane0;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [7:0]       rbyte;
    logic [1:0]       rresp;
  } bam_state_s;

  localparam bam_state_s STATE_RST = '0;

  function automatic logic bam_mapped(input logic [IDX_W-1:0] idx);
    return idx inside {IDX_BREAK_STAT_CTRL, IDX_BP_ADDR_HIGH, IDX_BP_ADDR_LOW,
                       IDX_BREAK_FLAG_CTRL, IDX_IRQ_STATUS, IDX_IRQ_MASK,
                       IDX_SYS_STATUS};
  endfunction

endpackage
`default_nettype wire

// ### hw/bam_match_if.sv
`default_nettype none
interface bam_match_if;
  logic [15:0] addr;
  logic [15:0] bp;
  logic        en;
  logic        is_pc;
  logic        stop;
  logic        hit;

  modport cmp (input addr, input bp, input en, input is_pc, input stop, output hit);
  modport ctl (output addr, output bp, output en, output is_pc, output stop, input hit);
endinterface
`default_nettype wire

// ### hw/bam_addr_match.sv
`default_nettype none
module bam_addr_match
  import bam_pkg::*;
(
  // comparator side
  bam_match_if.cmp m
);

  // full sixteen bit compare of program counter addresses only
  assign m.hit = m.en & m.is_pc & ~m.stop & (m.addr == m.bp);

endmodule
`default_nettype wire

// ### hw/bam_break_unit.sv
// Notes on behaviour
// - break waits for instruction end; match on last cycle starts at once
// - timer counter held stopped while break is in progress
// - watchdog disabled in break only while high voltage is on reset pin
// - works in wait mode; records that wait was left through a break
// - address matching inactive in stop mode; stop leaves all register values unchanged
// - enable bit 7 allows breaks on 16-bit match; write 0 or reset clears
// - hardware sets break active flag on an address match while no break is pending or active
// - software writing one to break active flag raises a break
// - reset clears break active flag
// - two byte registers hold breakpoint address high and low; reset clears
// - monitor mode fetches break vectors from FE page instead of FF page
// - break signals cpu to load software interrupt then vector
// - only program counter addresses are compared
// - flag clear enable decides if status may clear during break; the system status wait exit bit clears regardless
//
// The AXI4-Lite interface to the registers is this design's own decision.
`default_nettype none
module bam_break_unit
  import bam_pkg::*;
(
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              reset_n_i,
  input  wire logic              ce_i,
  // axi4-lite write address
  input  wire logic [AXI_AW-1:0] s_axi_awaddr_i,
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  // axi4-lite write data
  input  wire logic [31:0]       s_axi_wdata_i,
  input  wire logic [3:0]        s_axi_wstrb_i,
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  // axi4-lite write response
  output logic [1:0]             s_axi_bresp_o,
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  // axi4-lite read address
  input  wire logic [AXI_AW-1:0] s_axi_araddr_i,
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  // axi4-lite read data
  output logic [31:0]            s_axi_rdata_o,
  output logic [1:0]             s_axi_rresp_o,
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i,
  // cpu core
  input  wire logic [15:0]       cpu_addr_i,
  input  wire logic              cpu_addr_is_pc_i,
  input  wire logic              instr_last_cycle_i,
  input  wire logic              rti_exec_i,
  input  wire logic              wait_mode_i,
  input  wire logic              stop_mode_i,
  input  wire logic              monitor_mode_i,
  output logic                   break_start_o,
  output logic [15:0]            vec_addr_high_o,
  output logic [15:0]            vec_addr_low_o,
  // neighbours and pins
  input  wire logic              reset_pin_high_v_i,
  output logic                   timer_freeze_o,
  output logic                   watchdog_disable_o,
  output logic                   flag_clear_allow_o,
  output logic                   irq_o
);

  bam_state_s r;
  bam_state_s n;

  bam_match_if m ();

  logic             wr_go;
  logic             wr_ok;
  logic             wr_bsc;
  logic             wr_bph;
  logic             wr_bpl;
  logic             wr_bfc;
  logic             wr_ist;
  logic             wr_imk;
  logic             wr_sst;
  logic             sw_req;
  logic             in_break;
  logic             clr_ok;
  logic             brk_start;
  logic             brk_end;
  logic             idle_hit;
  logic [IDX_W-1:0] rd_idx;
  logic [7:0]       rd_byte;
  logic [IRQ_W-1:0] evt;

  // comparator hookup
  assign m.addr  = cpu_addr_i;
  assign m.bp    = {r.bp_hi, r.bp_lo};
  assign m.en    = r.bsc_en;
  assign m.is_pc = cpu_addr_is_pc_i;
  assign m.stop  = stop_mode_i;

  bam_addr_match u_match (
    .m (m.cmp)
  );

  // bus handshakes
  assign s_axi_awready_o = ce_i & ~r.aw_held & ~r.bvalid;
  assign s_axi_wready_o  = ce_i & ~r.w_held & ~r.bvalid;
  assign s_axi_arready_o = ce_i & ~r.rvalid;
  assign s_axi_bvalid_o  = r.bvalid;
  assign s_axi_bresp_o   = r.bresp;
  assign s_axi_rvalid_o  = r.rvalid;
  assign s_axi_rresp_o   = r.rresp;
  assign s_axi_rdata_o   = {24'h000000, r.rbyte};

  // write decode, performed once address and data are both held
  assign wr_go  = r.aw_held & r.w_held & ~r.bvalid;
  assign wr_ok  = wr_go & r.w_lane0;
  assign wr_bsc = wr_ok & (r.aw_idx == IDX_BREAK_STAT_CTRL);
  assign wr_bph = wr_ok & (r.aw_idx == IDX_BP_ADDR_HIGH);
  assign wr_bpl = wr_ok & (r.aw_idx == IDX_BP_ADDR_LOW);
  assign wr_bfc = wr_ok & (r.aw_idx == IDX_BREAK_FLAG_CTRL);
  assign wr_ist = wr_ok & (r.aw_idx == IDX_IRQ_STATUS);
  assign wr_imk = wr_ok & (r.aw_idx == IDX_IRQ_MASK);
  assign wr_sst = wr_ok & (r.aw_idx == IDX_SYS_STATUS);

  // software break request
  assign sw_req = wr_bsc & r.w_byte[BSC_ACTIVE_BIT];

  assign in_break = (r.brk_st == BRK_ACTIVE);
  assign clr_ok   = ~in_break | r.fcbe;
  assign idle_hit = m.hit & (r.brk_st == BRK_IDLE);

  // read mux
  assign rd_idx = s_axi_araddr_i[AXI_AW-1:2];

  always_comb begin
    rd_byte = BYTE_RST;
    case (rd_idx)
      IDX_BREAK_STAT_CTRL: begin
        rd_byte[BSC_ENABLE_BIT] = r.bsc_en;
        rd_byte[BSC_ACTIVE_BIT] = r.act;
      end
      IDX_BP_ADDR_HIGH: begin
        rd_byte = r.bp_hi;
      end
      IDX_BP_ADDR_LOW: begin
        rd_byte = r.bp_lo;
      end
      IDX_BREAK_FLAG_CTRL: begin
        rd_byte[BFC_FCBE_BIT] = r.fcbe;
      end
      IDX_IRQ_STATUS: begin
        rd_byte[IRQ_W-1:0] = r.ist;
      end
      IDX_IRQ_MASK: begin
        rd_byte[IRQ_W-1:0] = r.imk;
      end
      IDX_SYS_STATUS: begin
        rd_byte[SST_WAIT_BIT]  = r.wait_brk;
        rd_byte[SST_BREAK_BIT] = in_break;
        rd_byte[SST_HV_BIT]    = r.hv_s2;
      end
      default: begin
        rd_byte = BYTE_RST;
      end
    endcase
  end

  // next state
  always_comb begin
    n         = r;
    brk_start = 1'b0;
    brk_end   = 1'b0;
    evt       = IRQ_RST;

    // high voltage pin synchroniser
    n.hv_s1 = reset_pin_high_v_i;
    n.hv_s2 = r.hv_s1;

    // vector page select
    n.vec_hi = monitor_mode_i ? VEC_MON_HIGH : VEC_USER_HIGH;
    n.vec_lo = monitor_mode_i ? VEC_MON_LOW : VEC_USER_LOW;

    // break sequencer; in wait no instruction runs, so start at once
    case (r.brk_st)
      BRK_IDLE: begin
        if (m.hit | sw_req) begin
          if (instr_last_cycle_i | wait_mode_i) begin
            brk_start = 1'b1;
          end else begin
            n.brk_st = BRK_PEND;
          end
        end
      end
      BRK_PEND: begin
        if (instr_last_cycle_i | wait_mode_i) begin
          brk_start = 1'b1;
        end
      end
      BRK_ACTIVE: begin
        if (rti_exec_i) begin
          n.brk_st = BRK_IDLE;
          brk_end  = 1'b1;
        end
      end
      default: begin
        n.brk_st = BRK_IDLE;
      end
    endcase
    if (brk_start) begin
      n.brk_st = BRK_ACTIVE;
    end

    // enable and active flag, set wins over a written zero
    if (wr_bsc) begin
      n.bsc_en = r.w_byte[BSC_ENABLE_BIT];
      n.act    = r.w_byte[BSC_ACTIVE_BIT];
    end
    if (idle_hit) begin
      n.act = 1'b1;
    end

    // breakpoint address bytes
    if (wr_bph) begin
      n.bp_hi = r.w_byte;
    end
    if (wr_bpl) begin
      n.bp_lo = r.w_byte;
    end
    if (wr_bfc) begin
      n.fcbe = r.w_byte[BFC_FCBE_BIT];
    end

    // wait exit record
    if (wr_sst & ~r.w_byte[SST_WAIT_BIT]) begin
      n.wait_brk = 1'b0;
    end
    if (brk_start & wait_mode_i) begin
      n.wait_brk = 1'b1;
    end

    // interrupt status, write one to clear
    evt[IRQ_START_BIT] = brk_start;
    evt[IRQ_END_BIT]   = brk_end;
    evt[IRQ_WAIT_BIT]  = brk_start & wait_mode_i;
    if (wr_ist & clr_ok) begin
      n.ist = r.ist & ~r.w_byte[IRQ_W-1:0];
    end
    n.ist = n.ist | evt;
    if (wr_imk) begin
      n.imk = r.w_byte[IRQ_W-1:0];
    end

    // write channels
    if (s_axi_awvalid_i & s_axi_awready_o) begin
      n.aw_held = 1'b1;
      n.aw_idx  = s_axi_awaddr_i[AXI_AW-1:2];
    end
    if (s_axi_wvalid_i & s_axi_wready_o) begin
      n.w_held  = 1'b1;
      n.w_byte  = s_axi_wdata_i[7:0];
      n.w_lane0 = s_axi_wstrb_i[0];
    end
    if (wr_go) begin
      n.aw_held = 1'b0;
      n.w_held  = 1'b0;
      n.bvalid  = 1'b1;
      n.bresp   = bam_mapped(r.aw_idx) ? RESP_OKAY : RESP_SLVERR;
    end
    if (r.bvalid & s_axi_bready_i) begin
      n.bvalid = 1'b0;
    end

    // read channels
    if (s_axi_arvalid_i & s_axi_arready_o) begin
      n.rvalid = 1'b1;
      n.rbyte  = rd_byte;
      n.rresp  = bam_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
    end
    if (r.rvalid & s_axi_rready_i) begin
      n.rvalid = 1'b0;
    end
  end

  // state register; reset clears all flags and address bytes
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r <= STATE_RST;
    end else if (ce_i) begin
      r <= n;
    end
  end

  // outputs toward cpu and neighbours
  assign break_start_o      = brk_start & ce_i;
  assign vec_addr_high_o    = r.vec_hi;
  assign vec_addr_low_o     = r.vec_lo;
  assign timer_freeze_o     = in_break;
  assign watchdog_disable_o = in_break & r.hv_s2;
  assign flag_clear_allow_o = clr_ok;
  assign irq_o              = |(r.ist & r.imk);

  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  AST_START_AT_END: assert property (
    break_start_o |-> (instr_last_cycle_i || wait_mode_i))
    else $error("break started mid instruction");

  AST_LAST_CYCLE_NOW: assert property (
    (ce_i && m.hit && r.brk_st == BRK_IDLE && instr_last_cycle_i) |-> break_start_o)
    else $error("match on last cycle did not start break");

  AST_TIMER_HELD: assert property (
    (ce_i && break_start_o) |=> timer_freeze_o [*2] or
    (timer_freeze_o ##1 !timer_freeze_o && $past(rti_exec_i)))
    else $error("timer not held after break start");

  AST_WDOG_GATE: assert property (
    watchdog_disable_o |-> (timer_freeze_o && r.hv_s2))
    else $error("watchdog disabled outside break or without high voltage");

  AST_WAIT_RECORD: assert property (
    (ce_i && break_start_o && wait_mode_i) |=> r.wait_brk && r.ist[IRQ_WAIT_BIT])
    else $error("wait exit by break not recorded");

  AST_STOP_QUIET: assert property (
    stop_mode_i |-> !m.hit)
    else $error("match reported in stop mode");

  AST_ENABLE_GATE: assert property (
    m.hit |-> (r.bsc_en && cpu_addr_i == {r.bp_hi, r.bp_lo}))
    else $error("match without enable or full address equality");

  AST_ACTIVE_SET: assert property (
    (ce_i && idle_hit) |=> r.act)
    else $error("active flag not set on match");

  AST_SW_BREAK: assert property (
    (ce_i && sw_req && r.brk_st == BRK_IDLE && !instr_last_cycle_i && !wait_mode_i)
    |=> r.brk_st == BRK_PEND)
    else $error("software break request lost");

  AST_VEC_PAGE: assert property (
    (ce_i && monitor_mode_i) |=> (vec_addr_high_o == VEC_MON_HIGH &&
                                  vec_addr_low_o == VEC_MON_LOW))
    else $error("monitor vectors not selected");

  AST_PC_ONLY: assert property (
    m.hit |-> cpu_addr_is_pc_i)
    else $error("match on non program counter address");

  AST_RTI_END: assert property (
    (ce_i && timer_freeze_o && rti_exec_i) |=> !timer_freeze_o && !watchdog_disable_o)
    else $error("break did not end on return from interrupt");

endmodule
`default_nettype wire

// ### sim/bam_cpu_model.sv
`default_nettype none
module bam_cpu_model
  import bam_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  // bench control
  input  wire logic        run_i,
  input  wire logic        rti_req_i,
  input  wire logic [15:0] pc_base_i,
  input  wire logic [15:0] data_addr_i,
  // break unit
  input  wire logic        break_start_i,
  output logic [15:0]      cpu_addr_o,
  output logic             is_pc_o,
  output logic             last_o,
  output logic             rti_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0]  phase;
  logic [15:0] pc;
  logic        in_brk;
  // three-cycle instruction: fetch, operand, last
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      phase <= 2'h0;
      pc <= 16'h0000;
      in_brk <= 1'b0;
      rti_o <= 1'b0;
    end else begin
      rti_o <= in_brk & rti_req_i & !rti_o;
      if (break_start_i) begin
        in_brk <= 1'b1;
        phase <= 2'h0;
      end else if (rti_o) begin
        in_brk <= 1'b0;
      end else if (!run_i) begin
        pc <= pc_base_i;
        phase <= 2'h0;
      end else if (!in_brk) begin
        phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
        if (phase == 2'h2) pc <= pc + 16'h0002;
      end
    end
  end
  assign is_pc_o = run_i & !in_brk & (phase != 2'h1);
  assign last_o = run_i & !in_brk & (phase == 2'h2);
  // idle bus shows inverted pc, never a stale address
  assign cpu_addr_o = (phase == 2'h1) ? data_addr_i :
                      (is_pc_o ? pc + {15'h0, phase[1]} : ~pc);
endmodule
`default_nettype wire

// ### sim/bam_break_unit_tb.sv
`default_nettype none
module bam_break_unit_tb
  import bam_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] PCB = 16'h1230, DAT = 16'h4321;
  localparam logic [15:0] SC = IDX_BREAK_STAT_CTRL, IS = IDX_IRQ_STATUS;
  logic              clk_i = 1'b0, reset_n_i = 1'b0, ce_i = 1'b1;
  logic [AXI_AW-1:0] s_axi_awaddr_i = '0, s_axi_araddr_i = '0;
  logic [31:0]       s_axi_wdata_i = '0, s_axi_rdata_o;
  logic [3:0]        s_axi_wstrb_i = 4'h1;
  logic [1:0]        s_axi_bresp_o, s_axi_rresp_o;
  logic              s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_arvalid_i = 1'b0;
  // response readies held high, every answer taken at the edge it is seen
  logic              s_axi_bready_i = 1'b1, s_axi_rready_i = 1'b1;
  logic              s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
  logic              s_axi_arready_o, s_axi_rvalid_o;
  logic [15:0]       cpu_addr_i, vec_addr_high_o, vec_addr_low_o;
  logic              cpu_addr_is_pc_i, instr_last_cycle_i, rti_exec_i, break_start_o;
  logic              wait_mode_i = 1'b0, stop_mode_i = 1'b0, monitor_mode_i = 1'b0;
  logic              reset_pin_high_v_i = 1'b0, timer_freeze_o, watchdog_disable_o;
  logic              flag_clear_allow_o, irq_o, run = 1'b0, rti_req = 1'b0;
  int                fails = 0, num_checks = 0, nbrk = 0, cyc = 0;

  bam_break_unit i_bam_break_unit (.*);
  bam_cpu_model i_bam_cpu_model (
    .clk_i, .reset_n_i, .run_i(run), .rti_req_i(rti_req), .pc_base_i(PCB),
    .data_addr_i(DAT), .break_start_i(break_start_o), .cpu_addr_o(cpu_addr_i),
    .is_pc_o(cpu_addr_is_pc_i), .last_o(instr_last_cycle_i), .rti_o(rti_exec_i));

  always #12.5 clk_i = ~clk_i;

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc++;
    if (break_start_o === 1'b1) nbrk++;
    if (cyc == 20000) begin
      fails++;
      finish_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask

  // waits for the answer however long; only the cycle ceiling ends a hang
  task automatic wr(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] er);
    s_axi_awaddr_i <= {idx, 2'b00};
    s_axi_wdata_i <= {24'h0, d};
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_awvalid_i && s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wvalid_i && s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
    end while (s_axi_bvalid_o !== 1'b1);
    chk("bresp", er, s_axi_bresp_o);
  endtask

  task automatic rd(input logic [15:0] idx, input logic [7:0] e, input logic [1:0] er);
    s_axi_araddr_i <= {idx, 2'b00};
    s_axi_arvalid_i <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_arvalid_i && s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
    end while (s_axi_rvalid_o !== 1'b1);
    chk("rdata", {24'h0, e}, s_axi_rdata_o);
    chk("rresp", er, s_axi_rresp_o);
  endtask

  task automatic set_bp(input logic [15:0] a);
    wr(IDX_BP_ADDR_HIGH, a[15:8], RESP_OKAY);
    wr(IDX_BP_ADDR_LOW, a[7:0], RESP_OKAY);
    rd(IDX_BP_ADDR_HIGH, a[15:8], RESP_OKAY);
    rd(IDX_BP_ADDR_LOW, a[7:0], RESP_OKAY);
  endtask

  // cpu runs from the base address until a break starts or 40 cycles pass
  task automatic run_brk(input int e);
    int n;
    n = 0;
    run <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (break_start_o !== 1'b1 && n < 40);
    run <= 1'b0;
    chk("break_delay", e, n);
    // let the break state settle before callers look at it
    @(posedge clk_i);
  endtask

  task automatic idle_run(input int e);
    run <= 1'b1;
    repeat (12) @(posedge clk_i);
    run <= 1'b0;
    @(posedge clk_i);
    chk("break_count", e, nbrk);
  endtask

  task automatic do_rti();
    rti_req <= 1'b1;
    repeat (3) @(posedge clk_i);
    rti_req <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask

  initial begin
    repeat (4) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    rd(SC, BYTE_RST, RESP_OKAY);
    rd(IDX_BP_ADDR_HIGH, BYTE_RST, RESP_OKAY);
    rd(IDX_BP_ADDR_LOW, BYTE_RST, RESP_OKAY);
    rd(16'h0000, 8'h00, RESP_SLVERR);
    wr(16'h0000, 8'h5A, RESP_SLVERR);
    chk("vec_hi", VEC_USER_HIGH, vec_addr_high_o);
    chk("vec_lo", VEC_USER_LOW, vec_addr_low_o);
    // operand address, one-bit miss, then disabled exact match
    wr(SC, 8'h80, RESP_OKAY);
    set_bp(DAT);
    idle_run(0);
    set_bp(PCB ^ 16'h8000);
    idle_run(0);
    set_bp(PCB);
    wr(SC, 8'h00, RESP_OKAY);
    rd(SC, 8'h00, RESP_OKAY);
    idle_run(0);
    // match on first cycle waits for the last cycle
    wr(SC, 8'h80, RESP_OKAY);
    run_brk(3);
    chk("freeze", 1, timer_freeze_o);
    rd(SC, 8'hC0, RESP_OKAY);
    rd(IS, 8'h01, RESP_OKAY);
    chk("irq_masked", 0, irq_o);
    wr(IDX_IRQ_MASK, 8'h07, RESP_OKAY);
    chk("irq", 1, irq_o);
    chk("wdog", 0, watchdog_disable_o);
    reset_pin_high_v_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk("wdog_hv", 1, watchdog_disable_o);
    reset_pin_high_v_i <= 1'b0;
    chk("fclr", 0, flag_clear_allow_o);
    wr(IS, 8'h01, RESP_OKAY);
    rd(IS, 8'h01, RESP_OKAY);
    wr(IDX_BREAK_FLAG_CTRL, 8'h80, RESP_OKAY);
    chk("fclr_en", 1, flag_clear_allow_o);
    wr(IS, 8'h01, RESP_OKAY);
    rd(IS, 8'h00, RESP_OKAY);
    chk("irq_clr", 0, irq_o);
    wr(SC, 8'h80, RESP_OKAY);
    rd(SC, 8'h80, RESP_OKAY);
    do_rti();
    chk("unfreeze", 0, timer_freeze_o);
    chk("wdog_end", 0, watchdog_disable_o);
    rd(IS, 8'h02, RESP_OKAY);
    // match on the last cycle starts at once
    set_bp(PCB + 16'h0001);
    run_brk(3);
    do_rti();
    wr(IS, 8'h07, RESP_OKAY);
    // software request
    wr(SC, 8'h40, RESP_OKAY);
    run_brk(3);
    rd(SC, 8'h40, RESP_OKAY);
    do_rti();
    wr(IS, 8'h07, RESP_OKAY);
    // break taken while waiting
    wait_mode_i <= 1'b1;
    wr(SC, 8'h40, RESP_OKAY);
    repeat (2) @(posedge clk_i);
    chk("wait_freeze", 1, timer_freeze_o);
    // handler reads the wait exit bit, then writes zero to clear it
    rd(IDX_SYS_STATUS, 8'h03, RESP_OKAY);
    rd(IS, 8'h05, RESP_OKAY);
    wr(IDX_SYS_STATUS, 8'h00, RESP_OKAY);
    rd(IDX_SYS_STATUS, 8'h02, RESP_OKAY);
    wait_mode_i <= 1'b0;
    do_rti();
    chk("break_count", 4, nbrk);
    // stop mode ignores matches and keeps registers
    stop_mode_i <= 1'b1;
    set_bp(PCB);
    wr(SC, 8'h80, RESP_OKAY);
    idle_run(4);
    stop_mode_i <= 1'b0;
    rd(SC, 8'h80, RESP_OKAY);
    rd(IDX_BP_ADDR_HIGH, PCB[15:8], RESP_OKAY);
    rd(IDX_BP_ADDR_LOW, PCB[7:0], RESP_OKAY);
    // mid-run reset with the active flag set and a break pending
    wr(SC, 8'hC0, RESP_OKAY);
    rd(SC, 8'hC0, RESP_OKAY);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    rd(SC, BYTE_RST, RESP_OKAY);
    rd(IDX_BP_ADDR_HIGH, BYTE_RST, RESP_OKAY);
    rd(IDX_BP_ADDR_LOW, BYTE_RST, RESP_OKAY);
    // low byte lane not strobed, write has no effect
    s_axi_wstrb_i <= 4'h0;
    wr(IDX_BP_ADDR_HIGH, 8'hA5, RESP_OKAY);
    s_axi_wstrb_i <= 4'h1;
    rd(IDX_BP_ADDR_HIGH, BYTE_RST, RESP_OKAY);
    chk("break_count_rst", 4, nbrk);
    // clock enable low freezes the vector page
    ce_i <= 1'b0;
    monitor_mode_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("ce_hold", VEC_USER_HIGH, vec_addr_high_o);
    ce_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("mon_vec_hi", VEC_MON_HIGH, vec_addr_high_o);
    chk("mon_vec_lo", VEC_MON_LOW, vec_addr_low_o);
    finish_test();
  end
endmodule
`default_nettype wire
